// File: logic/lvmc_pkg.sv
package lvmc_pkg;
	// register byte offsets (word aligned)
	localparam logic [7:0] lvmc_status_offset = 8'h00; // voltage_monitor_status
	localparam logic [7:0] lvmc_config_offset = 8'h04; // config_register_one / two bits
	localparam logic [7:0] lvmc_irq_status_offset = 8'h08; // sticky event bits
	localparam logic [7:0] lvmc_irq_mask_offset = 8'h0C; // event mask
	localparam logic [7:0] lvmc_mode_offset = 8'h10; // wait / stop mode view
	// status register field positions
	localparam int lvmc_ack_bit = 0; // toggle_irq_ack, write only
	localparam int lvmc_ie_bit = 1; // toggle_irq_enable
	localparam int lvmc_if_bit = 6; // toggle_irq_flag
	localparam int lvmc_out_bit = 7; // low_supply_flag
	// config register field positions
	localparam int lvmc_pwrd_bit = 0; // monitor_power_down
	localparam int lvmc_rstd_bit = 1; // monitor_reset_disable
	localparam int lvmc_stop_bit = 2; // monitor_stop_enable
	localparam int lvmc_sel_lsb = 4; // trip_level_select[1:0]
	// trip selection encodings
	localparam logic [1:0] lvmc_sel_3v = 2'h0;
	localparam logic [1:0] lvmc_sel_5v = 2'h1;
	// sticky event bit positions
	localparam int lvmc_ev_fall = 0; // low_supply_flag went 0 to 1
	localparam int lvmc_ev_rise = 1; // low_supply_flag went 1 to 0
	localparam int lvmc_ev_reset = 2; // monitor reset requested
	localparam int lvmc_ev_count = 3;
	// reset values
	localparam logic [7:0] lvmc_config_reset = 8'h00; // monitoring on, resets on, 3V
	localparam logic [lvmc_ev_count-1:0] lvmc_mask_reset = 3'h0;
	// ahb transfer codes
	localparam logic [1:0] lvmc_htrans_nonseq = 2'h2;
	localparam logic [2:0] lvmc_hsize_word = 3'h2;
	// comparator pair as seen by the block
	typedef struct packed {
		logic below_fall; // supply under falling_trip_level
		logic above_rise; // supply over rising_trip_level
	} lvmc_cmp_type;
	// low power mode inputs
	typedef struct packed {
		logic wait_mode;
		logic stop_mode;
	} lvmc_mode_type;
endpackage

// File: logic/lvmc_monitor.sv
`timescale 1ns/1ps
module lvmc_monitor
	import lvmc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// analog comparators, asynchronous
	input wire lvmc_cmp_type cmp_async,
	// processor low power state
	input wire lvmc_mode_type cpu_mode,
	// to core and reset controller
	output logic toggle_irq_request,
	output logic monitor_reset_request,
	output logic reset_pin_n_out,
	output logic reset_pin_oe,
	output logic wake_request,
	output logic irq,
	output logic monitor_enable_out,
	output logic [1:0] trip_level_select_out
);

	// two flop synchronisers; stage one feeds only stage two
	lvmc_cmp_type cmp_meta;
	lvmc_cmp_type cmp_sync;
	// configuration bits
	logic monitor_power_down;
	logic monitor_reset_disable;
	logic monitor_stop_enable;
	logic [1:0] trip_level_select;
	// status bits
	logic low_supply_flag;
	logic toggle_irq_flag;
	logic toggle_irq_enable;
	logic monitor_reset_hold;
	logic [lvmc_ev_count-1:0] irq_status;
	logic [lvmc_ev_count-1:0] irq_mask;
	// ahb data phase capture
	logic dp_write;
	logic dp_read;
	logic [7:0] dp_addr;
	// derived
	logic monitor_active;
	logic next_low_supply_flag;
	logic flag_toggle;
	logic [lvmc_ev_count-1:0] events;
	logic wr_status;
	logic wr_config;
	logic wr_irq_status;
	logic wr_irq_mask;
	logic addr_phase;

	// bring comparator outputs into hclk before anything looks at them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_meta <= '0;
			cmp_sync <= '0;
		end else begin
			cmp_meta <= cmp_async;
			cmp_sync <= cmp_meta;
		end
	end

	// monitor gated by power-down, and by stop unless stop-enable is set
	always_comb begin
		monitor_active = !monitor_power_down;
		if (cpu_mode.stop_mode && !monitor_stop_enable) begin
			monitor_active = 1'b0;
		end
	end

	// hysteresis: set below falling level, clear above rising, else keep
	always_comb begin
		next_low_supply_flag = low_supply_flag;
		if (!monitor_active) begin
			next_low_supply_flag = low_supply_flag; // frozen while monitor is off
		end else if (cmp_sync.below_fall) begin
			next_low_supply_flag = 1'b1;
		end else if (cmp_sync.above_rise) begin
			next_low_supply_flag = 1'b0;
		end
	end

	assign flag_toggle = next_low_supply_flag != low_supply_flag;

	// ahb address phase accepted when selected, ready and nonseq/seq
	assign addr_phase = hsel && hready && htrans[1];
	assign wr_status = dp_write && (dp_addr == lvmc_status_offset);
	assign wr_config = dp_write && (dp_addr == lvmc_config_offset);
	assign wr_irq_status = dp_write && (dp_addr == lvmc_irq_status_offset);
	assign wr_irq_mask = dp_write && (dp_addr == lvmc_irq_mask_offset);

	// latch the address phase for the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			dp_write <= addr_phase && hwrite;
			dp_read <= addr_phase && !hwrite;
			dp_addr <= {haddr[7:2], 2'h0};
		end
	end

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// configuration; hresetn stands for power-on reset, so 3V comes back each time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			monitor_power_down <= lvmc_config_reset[lvmc_pwrd_bit];
			monitor_reset_disable <= lvmc_config_reset[lvmc_rstd_bit];
			monitor_stop_enable <= lvmc_config_reset[lvmc_stop_bit];
			trip_level_select <= lvmc_config_reset[lvmc_sel_lsb +: 2];
		end else if (wr_config) begin
			monitor_power_down <= hwdata[lvmc_pwrd_bit];
			monitor_reset_disable <= hwdata[lvmc_rstd_bit];
			monitor_stop_enable <= hwdata[lvmc_stop_bit];
			trip_level_select <= hwdata[lvmc_sel_lsb +: 2];
		end
	end

	// output flag register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_supply_flag <= 1'b0;
		end else begin
			low_supply_flag <= next_low_supply_flag;
		end
	end

	// monitor reset: armed on the falling trip, held until the rising trip
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			monitor_reset_hold <= 1'b0;
		end else if (!monitor_active || monitor_reset_disable) begin
			monitor_reset_hold <= 1'b0;
		end else if (cmp_sync.below_fall) begin
			monitor_reset_hold <= 1'b1;
		end else if (cmp_sync.above_rise) begin
			monitor_reset_hold <= 1'b0;
		end
	end

	// hold through the band between levels, and at reset release if still low
	assign monitor_reset_request = monitor_reset_hold;
	// active-low reset pin pulled while the reset is held, released otherwise
	assign reset_pin_n_out = 1'b0;
	assign reset_pin_oe = monitor_reset_hold;

	// toggle flag; a new toggle beats a same-cycle acknowledge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			toggle_irq_flag <= 1'b0;
		end else if (flag_toggle) begin
			toggle_irq_flag <= 1'b1;
		end else if (wr_status && hwdata[lvmc_ack_bit]) begin
			toggle_irq_flag <= 1'b0;
		end
	end

	// interrupt enable; a monitor reset clears it so reset wins over interrupt
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			toggle_irq_enable <= 1'b0;
		end else if (monitor_reset_hold) begin
			toggle_irq_enable <= 1'b0;
		end else if (wr_status) begin
			toggle_irq_enable <= hwdata[lvmc_ie_bit];
		end
	end

	// request is gated off during a monitor reset as well
	assign toggle_irq_request = toggle_irq_flag && toggle_irq_enable && !monitor_reset_hold;
	// either source can pull the core out of wait or stop
	assign wake_request = (toggle_irq_request || monitor_reset_hold)
		&& (cpu_mode.wait_mode || cpu_mode.stop_mode);

	// event vector for the sticky status register
	always_comb begin
		events = '0;
		events[lvmc_ev_fall] = flag_toggle && next_low_supply_flag;
		events[lvmc_ev_rise] = flag_toggle && !next_low_supply_flag;
		events[lvmc_ev_reset] = cmp_sync.below_fall && monitor_active && !monitor_reset_disable;
	end

	// sticky bits, write one to clear; set wins over clear per bit
	genvar gi;
	generate
		for (gi = 0; gi < lvmc_ev_count; gi++) begin : g_sticky
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					irq_status[gi] <= 1'b0;
				end else if (events[gi]) begin
					irq_status[gi] <= 1'b1;
				end else if (wr_irq_status && hwdata[gi]) begin
					irq_status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// mask register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask <= lvmc_mask_reset;
		end else if (wr_irq_mask) begin
			irq_mask <= hwdata[lvmc_ev_count-1:0];
		end
	end

	// level interrupt from unmasked sticky bits
	assign irq = |(irq_status & irq_mask);

	assign monitor_enable_out = monitor_active;
	assign trip_level_select_out = trip_level_select;

	// read data during the data phase; ack bit always reads zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (dp_read) begin
			unique case (dp_addr)
				lvmc_status_offset: begin
					hrdata[lvmc_out_bit] = low_supply_flag;
					hrdata[lvmc_if_bit] = toggle_irq_flag;
					hrdata[lvmc_ie_bit] = toggle_irq_enable;
					hrdata[lvmc_ack_bit] = 1'b0;
				end
				lvmc_config_offset: begin
					hrdata[lvmc_pwrd_bit] = monitor_power_down;
					hrdata[lvmc_rstd_bit] = monitor_reset_disable;
					hrdata[lvmc_stop_bit] = monitor_stop_enable;
					hrdata[lvmc_sel_lsb +: 2] = trip_level_select;
				end
				lvmc_irq_status_offset: begin
					hrdata[lvmc_ev_count-1:0] = irq_status;
				end
				lvmc_irq_mask_offset: begin
					hrdata[lvmc_ev_count-1:0] = irq_mask;
				end
				lvmc_mode_offset: begin
					hrdata[1:0] = {cpu_mode.wait_mode, cpu_mode.stop_mode};
				end
				default: begin
					hrdata = 32'h0000_0000; // unmapped reads zero
				end
			endcase
		end
	end

endmodule // lvmc_monitor

// File: verification/lvmc_monitor_sva.sv
`timescale 1ns/1ps
// port-level checks; delays follow the two-stage comparator synchroniser
module lvmc_monitor_sva
	import lvmc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire lvmc_cmp_type cmp_async,
	input wire lvmc_mode_type cpu_mode,
	input wire logic toggle_irq_request,
	input wire logic monitor_reset_request,
	input wire logic reset_pin_n_out,
	input wire logic reset_pin_oe,
	input wire logic wake_request,
	input wire logic monitor_enable_out,
	input wire logic [1:0] trip_level_select_out
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_BOOT_3V: assert property ($rose(hresetn) |-> trip_level_select_out == lvmc_sel_3v)
		else $error("trip select not 3V after reset");
	AST_BOOT_ON: assert property ($rose(hresetn) && !cpu_mode.stop_mode |-> monitor_enable_out)
		else $error("monitor off after reset");
	AST_PIN_LOW: assert property (reset_pin_oe == monitor_reset_request && !reset_pin_n_out)
		else $error("reset pin does not follow monitor reset");
	AST_RST_BEATS_IRQ: assert property (monitor_reset_request |-> !toggle_irq_request)
		else $error("interrupt requested during monitor reset");
	// the request may only rise once a low supply has passed the synchroniser
	AST_RST_CAUSE: assert property ($rose(monitor_reset_request) |-> $past(cmp_async.below_fall, 2)
		|| $past(cmp_async.below_fall, 3)) else $error("monitor reset without low supply");
	AST_HOLD: assert property ($fell(monitor_reset_request) |-> $past(cmp_async.above_rise, 2)
		|| $past(cmp_async.above_rise, 3) || $past(hsel && htrans[1] && hwrite, 2)
		|| $past(hsel && htrans[1] && hwrite, 3)) else $error("monitor reset released early");
	AST_WAKE: assert property (wake_request == ((cpu_mode.wait_mode || cpu_mode.stop_mode)
		&& (toggle_irq_request || monitor_reset_request))) else $error("wake request wrong");
	AST_ACK_ZERO: assert property (hsel && hready && htrans[1] && !hwrite && haddr == lvmc_status_offset
		|=> hrdata[lvmc_ack_bit] == 1'b0) else $error("ack bit reads one");
endmodule // lvmc_monitor_sva

bind lvmc_monitor lvmc_monitor_sva i_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.cmp_async, .cpu_mode, .toggle_irq_request, .monitor_reset_request, .reset_pin_n_out, .reset_pin_oe,
	.wake_request, .monitor_enable_out, .trip_level_select_out);

// File: verification/lvmc_core_model.sv
`timescale 1ns/1ps
// core low power state: sleeps on command, wakes on the block's request
module lvmc_core_model
	import lvmc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go_wait,
	input wire logic go_stop,
	input wire logic wake_request,
	output lvmc_mode_type cpu_mode
);
	// wake wins over a new entry so a pending event is never slept through
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_mode <= '0;
		end else if (wake_request) begin
			cpu_mode <= '0;
		end else if (go_wait || go_stop) begin
			cpu_mode <= {go_wait, go_stop};
		end
	end
endmodule // lvmc_core_model

// File: verification/tb_low_voltage_monitor_control.sv
`timescale 1ns/1ps
module tb_low_voltage_monitor_control;
	import lvmc_pkg::*;
	localparam logic [31:0] s_out = 32'h1 << lvmc_out_bit; // status view masks
	localparam logic [31:0] s_if = 32'h1 << lvmc_if_bit;
	localparam logic [31:0] s_ie = 32'h1 << lvmc_ie_bit;
	localparam logic [31:0] s_ack = 32'h1 << lvmc_ack_bit;
	localparam logic [31:0] c_rstd = 32'h1 << lvmc_rstd_bit;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	lvmc_cmp_type cmp = '0; // comparator levels in place of the analog side
	logic go_wait = 1'b0;
	logic go_stop = 1'b0;
	lvmc_mode_type mode;
	logic [31:0] hrdata;
	logic hreadyout, hresp, irq_req, rst_req, pin_n, pin_oe, wake, irq, mon_en;
	logic [1:0] trip;
	logic [31:0] rd;
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	always #4 hclk = ~hclk;
	lvmc_monitor i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(lvmc_hsize_word), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cmp_async(cmp), .cpu_mode(mode), .toggle_irq_request(irq_req),
		.monitor_reset_request(rst_req), .reset_pin_n_out(pin_n), .reset_pin_oe(pin_oe), .wake_request(wake),
		.irq(irq), .monitor_enable_out(mon_en), .trip_level_select_out(trip));
	lvmc_core_model i_core (.hclk(hclk), .hresetn(hresetn), .go_wait(go_wait), .go_stop(go_stop),
		.wake_request(wake), .cpu_mode(mode));
	// one single transfer; values are taken at the negedge before the sampling edge to avoid races
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		logic rdy;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= lvmc_htrans_nonseq;
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			@(posedge hclk);
		end while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			rd = hrdata;
			@(posedge hclk);
		end while (rdy !== 1'b1);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge hclk);
	endtask
	task automatic drv(input lvmc_cmp_type c);
		@(posedge hclk);
		cmp <= c;
		wt(8);
	endtask
	task automatic t_reset;
		chk({pin_oe, irq, irq_req, rst_req, mon_en, trip}, {5'h01, lvmc_sel_3v});
		chk({hreadyout, hresp}, 2'h2); // zero wait states, always okay
		rdchk(lvmc_status_offset, 32'h0);
		rdchk(lvmc_config_offset, {24'h0, lvmc_config_reset});
		rdchk(8'h1C, 32'h0);
		$display("test reset done");
	endtask
	// interrupts without resets: flag, enable, ack, hysteresis and event mask
	task automatic t_polled;
		bus(lvmc_config_offset, 1'b1, c_rstd);
		bus(lvmc_status_offset, 1'b1, s_ie);
		bus(lvmc_irq_mask_offset, 1'b1, 32'h1 << lvmc_ev_fall);
		drv(2'h2);
		chk({rst_req, irq_req, irq}, 3'h3);
		bus(lvmc_irq_status_offset, 1'b1, 32'h1 << lvmc_ev_fall);
		bus(lvmc_status_offset, 1'b1, s_ie);
		rdchk(lvmc_status_offset, s_out | s_if | s_ie);
		chk(irq, 1'b0);
		bus(lvmc_status_offset, 1'b1, s_ie | s_ack);
		drv(2'h0);
		rdchk(lvmc_status_offset, s_out | s_ie);
		drv(2'h1);
		rdchk(lvmc_status_offset, s_if | s_ie);
		chk({irq_req, irq}, 2'h2);
		bus(lvmc_status_offset, 1'b1, 32'h0);
		wt(2);
		chk(irq_req, 1'b0);
		bus(lvmc_status_offset, 1'b1, s_ack);
		bus(lvmc_irq_status_offset, 1'b1, 32'h7);
		$display("test polled done");
	endtask
	task automatic t_forced;
		bus(lvmc_config_offset, 1'b1, 32'h0);
		bus(lvmc_status_offset, 1'b1, s_ie);
		drv(2'h2);
		chk({rst_req, pin_oe, pin_n, irq_req}, 4'hC);
		rdchk(lvmc_status_offset, s_out | s_if);
		drv(2'h0);
		chk(rst_req, 1'b1);
		drv(2'h1);
		chk(rst_req, 1'b0);
		bus(lvmc_status_offset, 1'b1, s_ack);
		bus(lvmc_irq_status_offset, 1'b1, 32'h7);
		$display("test forced done");
	endtask
	// wait always wakes; stop wakes only once the stop enable is set
	task automatic t_lowpower;
		bus(lvmc_config_offset, 1'b1, c_rstd);
		bus(lvmc_status_offset, 1'b1, s_ie);
		@(posedge hclk);
		go_wait <= 1'b1;
		@(posedge hclk);
		go_wait <= 1'b0;
		wt(2);
		chk(mode, 2'h2);
		drv(2'h2);
		chk(mode, 2'h0);
		bus(lvmc_status_offset, 1'b1, s_ie | s_ack);
		@(posedge hclk);
		go_stop <= 1'b1;
		@(posedge hclk);
		go_stop <= 1'b0;
		drv(2'h1);
		chk({mode, mon_en}, 3'h2);
		rdchk(lvmc_mode_offset, 32'h1);
		bus(lvmc_config_offset, 1'b1, c_rstd | (32'h1 << lvmc_stop_bit));
		wt(8);
		chk(mode, 2'h0);
		$display("test lowpower done");
	endtask
	task automatic t_pwrd;
		bus(lvmc_status_offset, 1'b1, s_ack);
		bus(lvmc_config_offset, 1'b1, (32'h1 << lvmc_pwrd_bit) | (32'(lvmc_sel_5v) << lvmc_sel_lsb));
		wt(2);
		chk({mon_en, trip}, {1'b0, lvmc_sel_5v});
		drv(2'h2);
		rdchk(lvmc_status_offset, 32'h0);
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		wt(1);
		chk(trip, lvmc_sel_3v);
		wt(6);
		chk(rst_req, 1'b1);
		drv(2'h1);
		chk(rst_req, 1'b0);
		$display("test powerdown done");
	endtask
	task automatic end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard, far beyond the few hundred cycles the tests need
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 4000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		wt(1);
		t_reset();
		t_polled();
		t_forced();
		t_lowpower();
		t_pwrd();
		end_sim();
	end
endmodule // tb_low_voltage_monitor_control
